// file: spc_pkg.sv
// Package with register map, field layout and reset values of the output and index configuration bank
package spc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_AB_OUTPUT_GAIN_CTRL   = 8'h01;
    localparam logic [7:0] ADR_INDEX_PATH_CTRL       = 8'h02;
    localparam logic [7:0] ADR_INPUT_CHECK_CTRL      = 8'h03;
    localparam logic [7:0] ADR_FILTER_POWERDOWN_CTRL = 8'h04;
    localparam logic [7:0] ADR_INDEX_GAIN_OFFSET     = 8'h06;
    localparam logic [7:0] ADR_INDEX_GAIN_LOW        = 8'h07;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_AB_OUT_GAIN      = 6;
    localparam int POS_INDEX_INVERT     = 0;
    localparam int POS_INDEX_SINGLE     = 1;
    localparam int POS_INDEX_CMP_SKIP   = 2;
    localparam int POS_INDEX_LEVEL_MODE = 3;
    localparam int POS_INDEX_OUT_GAIN   = 4;
    localparam int POS_INDEX_CHECK_EN   = 1;
    localparam int POS_CHAN_A_PD        = 0;
    localparam int POS_CHAN_B_PD        = 1;
    localparam int POS_INDEX_PD         = 2;
    localparam int POS_FILTER           = 3;
    localparam int POS_INDEX_OFFSET     = 0;
    localparam int POS_INDEX_GAIN_MSB   = 7;
    localparam int POS_INDEX_GAIN_LOW   = 0;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG        = 8'h00;
    localparam logic [1:0] GAIN_CODE_6DB  = 2'h2;
    localparam logic [1:0] GAIN_CODE_RSVD = 2'h1;
    localparam logic [1:0] FILT_CODE_RSVD = 2'h3;
    localparam logic [2:0] IDX_GAIN_MAX   = 3'h6;
    localparam logic [5:0] IDX_OFS_NEG    = 6'h20;

    typedef enum logic [1:0] {SPC_GAIN_0DB, SPC_GAIN_RSVD, SPC_GAIN_P6DB, SPC_GAIN_M3DB} spc_gain_e;

endpackage

// file: spc_reg_if.sv
// Interface carrying register write strobe, write data, read index and read data between bank and storage
`timescale 1ns/1ps
interface spc_reg_if;
    logic       wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;

    modport bank (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// file: spc_reg_mem.sv
// Small register storage with registered read data
`timescale 1ns/1ps
module spc_reg_mem
    import spc_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   clk_en,
    spc_reg_if.store    bus,
    output logic [63:0] flat
);
    logic [7:0] mem      [8];
    logic [7:0] next_mem [8];
    logic [7:0] next_rd;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_mem = mem;
        next_rd  = mem[bus.rd_idx];
        if (bus.wr_en) begin
            next_mem[bus.wr_idx] = bus.wr_data;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                mem[i] <= RST_REG;
            end
            bus.rd_data <= RST_REG;
        end else if (clk_en) begin
            mem         <= next_mem;
            bus.rd_data <= next_rd;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            flat[i*8 +: 8] = mem[i];
        end
    end
endmodule

// file: spc_config_bank.sv
// Output driver and index channel configuration register bank
`timescale 1ns/1ps
// Behaviour
// RL1 - A/B output gain at 0x01[7:6]: 0 dB, reserved, +6 dB, -3 dB; reset 0
// RL2 - A/B output gain code is passed to automatic gain compensation
// RL3 - Filter at 0x04[4:3]: 1 MHz, 500 kHz, 200 kHz, reserved; reset 0
// RL4 - 0x04 bits 0 and 1 power down channels A and B, outputs high impedance
// RL5 - Software should stop dynamic adaption while A or B is powered down
// RL6 - Index coarse gain is code times 6 dB, legal up to code 6
// RL7 - Index gain MSB from 0x06 bit 7, low bits from 0x07 bits 1:0
// RL8 - Index offset 0x06[5:0] two's complement, limited to -31..+31, 60 mV per step
// RL9 - Index offset is adjusted by temperature compensation from a look-up table
// RL10 - 0x02 bit 1 ties the negative index input to mid-supply reference
// RL11 - 0x02 bit 3 selects rail-to-rail, only valid with index output gain 0x2
// RL12 - 0x02 bit 2 bypasses the index zero-crossing comparator
// RL13 - Index output gain at 0x02[5:4]: 0 dB, reserved, +6 dB, -3 dB
// RL14 - 0x03 bit 1 connects index pull-ups and enables index error reporting
// RL15 - 0x04 bit 2 powers down the index path, outputs high impedance
// RL16 - 0x02 bit 0 inverts the index output
// RL17 - With checking on, a floating index input raises the sensor error; the code raises it only while 0x04 bit 2 leaves the index path powered up
// RL18 - All fields clear to zero on reset and drive decoded controls continuously
module spc_config_bank
    import spc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic signed [5:0] temp_offset_adj,
    input  wire logic       index_input_floating,
    output logic      [1:0] ab_out_gain_sel,
    output logic      [1:0] agc_out_gain_code,
    output logic            ab_out_gain_reserved,
    output logic      [1:0] filter_sel,
    output logic            filter_reserved,
    output logic            chan_a_power_down,
    output logic            chan_b_power_down,
    output logic            chan_a_out_en,
    output logic            chan_b_out_en,
    output logic            index_invert,
    output logic            index_single_ended,
    output logic            index_neg_input_mid_ref,
    output logic            index_comparator_skip,
    output logic            index_out_level_mode,
    output logic            index_rail_to_rail,
    output logic      [1:0] index_out_gain_sel,
    output logic            index_out_gain_reserved,
    output logic            index_input_check_en,
    output logic            index_pullup_en,
    output logic            index_sig_error,
    output logic            index_power_down,
    output logic            index_out_en,
    output logic      [2:0] index_coarse_gain,
    output logic            index_gain_illegal,
    output logic signed [5:0] index_offset_code,
    output logic signed [5:0] index_offset_eff
);
    spc_reg_if  rbus ();
    logic [63:0] flat;
    logic [7:0] r01, r02, r03, r04, r06, r07;
    logic       next_rvalid;
    logic       next_err;
    logic       rd_pend;
    logic       err_q;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic adr_mapped(input logic [7:0] a);
        return (a == ADR_AB_OUTPUT_GAIN_CTRL) || (a == ADR_INDEX_PATH_CTRL)
            || (a == ADR_INPUT_CHECK_CTRL) || (a == ADR_FILTER_POWERDOWN_CTRL)
            || (a == ADR_INDEX_GAIN_OFFSET) || (a == ADR_INDEX_GAIN_LOW);
    endfunction

    function automatic logic signed [5:0] clamp31(input logic signed [6:0] v);
        if (v > 7'sd31) begin
            return 6'sd31;
        end else if (v < -7'sd31) begin
            return -6'sd31;
        end
        return v[5:0];
    endfunction

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    assign rbus.wr_en   = clk_en & reg_wr & adr_mapped(reg_addr);
    assign rbus.wr_idx  = reg_addr[2:0];
    assign rbus.wr_data = reg_wdata;
    // Unmapped reads land on slot 0, which no write ever reaches
    assign rbus.rd_idx  = adr_mapped(reg_addr) ? reg_addr[2:0] : 3'h0;

    spc_reg_mem u_mem (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clk_en  (clk_en),
        .bus     (rbus),
        .flat    (flat)
    );

    assign r01 = flat[8*1 +: 8];
    assign r02 = flat[8*2 +: 8];
    assign r03 = flat[8*3 +: 8];
    assign r04 = flat[8*4 +: 8];
    assign r06 = flat[8*6 +: 8];
    assign r07 = flat[8*7 +: 8];

    always_comb begin
        next_rvalid    = reg_rd & ~reg_wr;
        next_err       = index_input_check_en & index_input_floating & ~index_power_down; // see RL17
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_pend     <= 1'b0;
            err_q       <= 1'b0;
        end else if (clk_en) begin
            rd_pend     <= next_rvalid;
            err_q       <= next_err;
        end
    end

    assign reg_rvalid = rd_pend;
    assign reg_rdata  = rbus.rd_data;

    // ------------------------------------------------------------
    // A/B output driver decode
    // ------------------------------------------------------------
    assign ab_out_gain_sel      = r01[POS_AB_OUT_GAIN +: 2];                // see RL1
    assign ab_out_gain_reserved = (ab_out_gain_sel == GAIN_CODE_RSVD);      // see RL1
    assign agc_out_gain_code    = ab_out_gain_sel;                          // see RL2
    assign filter_sel           = r04[POS_FILTER +: 2];                     // see RL3
    assign filter_reserved      = (filter_sel == FILT_CODE_RSVD);           // see RL3
    assign chan_a_power_down    = r04[POS_CHAN_A_PD];                       // see RL4
    assign chan_b_power_down    = r04[POS_CHAN_B_PD];                       // see RL4
    assign chan_a_out_en        = ~chan_a_power_down;                       // see RL4
    assign chan_b_out_en        = ~chan_b_power_down;                       // see RL4

    // ------------------------------------------------------------
    // Index path decode
    // ------------------------------------------------------------
    assign index_invert            = r02[POS_INDEX_INVERT];                 // see RL16
    assign index_single_ended      = r02[POS_INDEX_SINGLE];                 // see RL10
    assign index_neg_input_mid_ref = index_single_ended;                    // see RL10
    assign index_comparator_skip   = r02[POS_INDEX_CMP_SKIP];               // see RL12
    assign index_out_level_mode    = r02[POS_INDEX_LEVEL_MODE];             // see RL11
    assign index_out_gain_sel      = r02[POS_INDEX_OUT_GAIN +: 2];          // see RL13
    assign index_out_gain_reserved = (index_out_gain_sel == GAIN_CODE_RSVD); // see RL13
    assign index_rail_to_rail      = index_out_level_mode & (index_out_gain_sel == GAIN_CODE_6DB); // see RL11
    assign index_input_check_en    = r03[POS_INDEX_CHECK_EN];               // see RL14
    assign index_pullup_en         = index_input_check_en;                  // see RL14
    assign index_sig_error         = err_q;                                 // see RL17
    assign index_power_down        = r04[POS_INDEX_PD];                     // see RL15
    assign index_out_en            = ~index_power_down;                     // see RL15
    assign index_coarse_gain       = {r06[POS_INDEX_GAIN_MSB], r07[POS_INDEX_GAIN_LOW +: 2]}; // see RL7
    assign index_gain_illegal      = (index_coarse_gain > IDX_GAIN_MAX);    // see RL6
    assign index_offset_code       = (r06[POS_INDEX_OFFSET +: 6] == IDX_OFS_NEG) ? -6'sd31
                                     : $signed(r06[POS_INDEX_OFFSET +: 6]); // see RL8
    assign index_offset_eff        = clamp31(7'(index_offset_code) + 7'(temp_offset_adj)); // see RL9

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reset_clears_fields: assert property (@(posedge clk_sys) $fell(rst) |-> // see RL18
        (r01 == 8'h00 && r02 == 8'h00 && r03 == 8'h00 && r04 == 8'h00 && r06 == 8'h00 && r07 == 8'h00
        && !index_sig_error)) else $error("fields not cleared by reset");
    a_ab_gain_write: assert property (@(posedge clk_sys) disable iff (rst) // see RL1
        (clk_en && reg_wr && reg_addr == 8'h01) |=> ab_out_gain_sel == $past(reg_wdata[7:6]))
        else $error("ab gain not stored");
    a_agc_gain_follow: assert property (@(posedge clk_sys) disable iff (rst) // see RL2
        agc_out_gain_code == r01[7:6]) else $error("agc gain code mismatch");
    a_filter_write: assert property (@(posedge clk_sys) disable iff (rst) // see RL3
        (clk_en && reg_wr && reg_addr == 8'h04) |=> filter_sel == $past(reg_wdata[4:3]))
        else $error("filter not stored");
    a_chan_pd_hiz: assert property (@(posedge clk_sys) disable iff (rst) // see RL4
        (clk_en && reg_wr && reg_addr == 8'h04 && reg_wdata[0]) |=> !chan_a_out_en)
        else $error("channel a still driven");
    a_index_gain_join: assert property (@(posedge clk_sys) disable iff (rst) // see RL7
        (clk_en && reg_wr && reg_addr == 8'h07) |=> index_coarse_gain[1:0] == $past(reg_wdata[1:0]))
        else $error("index gain low bits wrong");
    a_offset_range: assert property (@(posedge clk_sys) disable iff (rst) // see RL8
        index_offset_code != 6'sh20 && index_offset_eff != 6'sh20) else $error("offset out of range");
    a_rail_needs_gain: assert property (@(posedge clk_sys) disable iff (rst) // see RL11
        index_rail_to_rail |-> index_out_gain_sel == 2'h2) else $error("rail mode with wrong gain");
    a_index_pd_hiz: assert property (@(posedge clk_sys) disable iff (rst) // see RL15
        (clk_en && reg_wr && reg_addr == 8'h04) |=> index_out_en == !$past(reg_wdata[2]))
        else $error("index enable wrong");
    a_sig_error_cause: assert property (@(posedge clk_sys) disable iff (rst) // see RL17
        (clk_en && index_input_check_en && index_input_floating && !index_power_down) |=> index_sig_error)
        else $error("sensor error not raised");
    a_polarity_write: assert property (@(posedge clk_sys) disable iff (rst) // see RL16
        (clk_en && reg_wr && reg_addr == 8'h02) |=> index_invert == $past(reg_wdata[0])
        && index_comparator_skip == $past(reg_wdata[2]) && index_single_ended == $past(reg_wdata[1]))
        else $error("index control bits not stored"); // see RL10 RL12
    a_check_enable: assert property (@(posedge clk_sys) disable iff (rst) // see RL14
        (clk_en && !index_input_check_en) |=> !index_sig_error) else $error("error reported while disabled");
    a_index_gain_write: assert property (@(posedge clk_sys) disable iff (rst) // see RL13
        (clk_en && reg_wr && reg_addr == 8'h02) |=> index_out_gain_sel == $past(reg_wdata[5:4])
        && index_out_level_mode == $past(reg_wdata[3])) else $error("index output gain not stored");
    a_chan_b_pd: assert property (@(posedge clk_sys) disable iff (rst) // see RL4
        (clk_en && reg_wr && reg_addr == 8'h04) |=> chan_b_out_en == !$past(reg_wdata[1])
        && chan_a_out_en == !$past(reg_wdata[0])) else $error("channel enables wrong");
    a_pullup_write: assert property (@(posedge clk_sys) disable iff (rst) // see RL14
        (clk_en && reg_wr && reg_addr == 8'h03) |=> index_pullup_en == $past(reg_wdata[1]))
        else $error("index pull-up enable not stored");
    a_gain_msb_join: assert property (@(posedge clk_sys) disable iff (rst) // see RL7
        (clk_en && reg_wr && reg_addr == 8'h06) |=> index_coarse_gain[2] == $past(reg_wdata[7]))
        else $error("index gain msb wrong");
    a_gain_over_max: assert property (@(posedge clk_sys) disable iff (rst) // see RL6
        (clk_en && reg_wr && reg_addr == 8'h07 && reg_wdata[1:0] == 2'h3 && index_coarse_gain[2])
        |=> index_gain_illegal) else $error("gain code 7 not flagged");
    a_offset_write: assert property (@(posedge clk_sys) disable iff (rst) // see RL8
        (clk_en && reg_wr && reg_addr == 8'h06 && reg_wdata[5:0] != 6'h20)
        |=> index_offset_code == $signed($past(reg_wdata[5:0]))) else $error("index offset not stored");
    a_offset_no_adj: assert property (@(posedge clk_sys) disable iff (rst) // see RL9
        temp_offset_adj == 6'sh00 |-> index_offset_eff == index_offset_code) else $error("offset moved without adj");
    a_read_valid: assert property (@(posedge clk_sys) disable iff (rst) // see RL18
        (clk_en && reg_rd && !reg_wr) |=> reg_rvalid) else $error("read not answered");
endmodule

// file: spc_config_bank_bench.sv
// Self-checking testbench for the output and index configuration bank
`timescale 1ns/1ps
module spc_config_bank_bench
    import spc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_sys, rst, clk_en, reg_wr, reg_rd, reg_rvalid, index_input_floating;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic signed [5:0] temp_offset_adj, index_offset_code, index_offset_eff;
    logic [1:0] ab_out_gain_sel, agc_out_gain_code, filter_sel, index_out_gain_sel;
    logic ab_out_gain_reserved, filter_reserved, chan_a_power_down, chan_b_power_down;
    logic chan_a_out_en, chan_b_out_en, index_invert, index_single_ended, index_neg_input_mid_ref;
    logic index_comparator_skip, index_out_level_mode, index_rail_to_rail, index_out_gain_reserved;
    logic index_input_check_en, index_pullup_en, index_sig_error, index_power_down, index_out_en;
    logic [2:0] index_coarse_gain;
    logic index_gain_illegal;
    logic [7:0] m [0:255];
    logic [31:0] lfsr_q;
    logic [15:0] corner [0:9];
    int bad_count, samples_checked;

    spc_config_bank dut_u (.*);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [5:0] ofs(input logic [5:0] c);
        return (c == 6'h20) ? 6'h21 : c;
    endfunction

    function automatic logic [5:0] ofs_eff(input logic [5:0] c, input logic [5:0] adj);
        int s;
        s = int'($signed(ofs(c))) + int'($signed(adj));
        s = (s > 31) ? 31 : ((s < -31) ? -31 : s);
        return s[5:0];
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        if (clk_en === 1'b1 && a inside {ADR_AB_OUTPUT_GAIN_CTRL, ADR_INDEX_PATH_CTRL, ADR_INPUT_CHECK_CTRL,
                                         ADR_FILTER_POWERDOWN_CTRL, ADR_INDEX_GAIN_OFFSET, ADR_INDEX_GAIN_LOW}) begin
            m[a] = d;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk("readback", {8'h01, m[a]}, {7'h00, reg_rvalid, reg_rdata});
    endtask

    task automatic check_outputs();
        logic [7:0] r1, r2, r3, r4, r6, r7;
        @(negedge clk_sys);
        r1 = m[1];
        r2 = m[2];
        r3 = m[3];
        r4 = m[4];
        r6 = m[6];
        r7 = m[7];
        chk("ab_path", {4'h0, r1[7:6], r1[7:6], r1[7:6] == 2'h1, r4[4:3], r4[4:3] == 2'h3, r4[0], r4[1], ~r4[0], ~r4[1]},
            {4'h0, ab_out_gain_sel, agc_out_gain_code, ab_out_gain_reserved, filter_sel, filter_reserved,
             chan_a_power_down, chan_b_power_down, chan_a_out_en, chan_b_out_en});
        chk("index_ctrl", {7'h00, r2[0], r2[1], r2[1], r2[2], r2[3], r2[3] && r2[5:4] == 2'h2, r2[5:4], r2[5:4] == 2'h1},
            {7'h00, index_invert, index_single_ended, index_neg_input_mid_ref, index_comparator_skip,
             index_out_level_mode, index_rail_to_rail, index_out_gain_sel, index_out_gain_reserved});
        chk("index_check", {11'h000, r3[1], r3[1], r4[2], ~r4[2], r3[1] & index_input_floating & ~r4[2]},
            {11'h000, index_input_check_en, index_pullup_en, index_power_down, index_out_en,
             index_sig_error});
        chk("index_gain", {r6[7], r7[1:0], {r6[7], r7[1:0]} > 3'h6, ofs(r6[5:0]), ofs_eff(r6[5:0], temp_offset_adj)},
            {index_coarse_gain, index_gain_illegal, index_offset_code, index_offset_eff});
    endtask

    task automatic results();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        bad_count++;
        results();
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        corner = '{16'h06A0, 16'h0703, 16'h061F, 16'h0228, 16'h0238, 16'h0140, 16'h0418, 16'h0407, 16'h0302, 16'h0561};
        foreach (m[i]) m[i] = 8'h00;
        rst = 1'b1;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        temp_offset_adj = 6'sd31;
        index_input_floating = 1'b1;
        lfsr_q = 32'hb137;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        check_outputs();
        for (int a = 0; a < 8; a++) rd(8'(a));
        foreach (corner[i]) begin
            wr(corner[i][15:8], corner[i][7:0]);
            check_outputs();
            rd(corner[i][15:8]);
        end
        temp_offset_adj = -6'sd31;
        wr(ADR_INDEX_GAIN_OFFSET, 8'h21);
        check_outputs();
        clk_en = 1'b0;
        wr(ADR_INDEX_PATH_CTRL, 8'hFF);
        check_outputs();
        clk_en = 1'b1;
        reg_rd = 1'b1;
        wr(ADR_INPUT_CHECK_CTRL, 8'h00);
        reg_rd = 1'b0;
        chk("rvalid_on_write", 16'h0000, {15'h0000, reg_rvalid});
        check_outputs();
        for (int i = 0; i < 300; i++) begin
            logic [7:0] adr;
            lfsr_q = lfsr(lfsr_q);
            index_input_floating = lfsr_q[16];
            temp_offset_adj = lfsr_q[22:17];
            adr = {5'h00, lfsr_q[2:0]} + {7'h00, lfsr_q[31]};
            wr(adr, lfsr_q[15:8] & ((adr == ADR_AB_OUTPUT_GAIN_CTRL) ? 8'hFD : 8'hFF));
            check_outputs();
            rd(adr);
        end
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        foreach (m[i]) m[i] = 8'h00;
        check_outputs();
        for (int a = 0; a < 8; a++) rd(8'(a));
        results();
    end
endmodule
